// ---- host_irq_dma_modem_pins.sv ----
/*
 * Host-side pin logic of a dual-channel serial controller: data bus answer,
 * open-drain interrupt with vector acknowledge and daisy chain, DMA requests,
 * shared ready/DMA pins and modem control with auto enable.
 * Assumes the serial core supplies buffer status and that all inputs are
 * synchronous to MCLK_I except the modem, chain and acknowledge pins.
 */
`timescale 1ns/1ns
`include "host_pins_regs.svh"
`default_nettype none
module host_irq_dma_modem_pins (
    input  wire logic                   MCLK_I,
    input  wire logic                   NRST_I,
    input  wire logic [3:0]             ADDR_I,
    input  wire logic [7:0]             DATA_I,
    input  wire logic                   WR_I,
    input  wire logic                   RD_I,
    output logic      [7:0]             DATA_O,
    output logic                        DATA_OE_O,
    output logic                        IRQ_O,
    output logic                        IRQ_OE_O,
    input  wire logic                   VECTOR_ACK_N_I,
    input  wire logic                   DAISY_IN_N_I,
    output logic                        DAISY_OUT_N_O,
    output logic                        DMA_TX_REQ_A_O,
    output logic                        DMA_RX_REQ_A_O,
    output logic                        READY_A_OR_DMA_TX_B_O,
    output logic                        READY_B_OR_DMA_RX_B_O,
    input  wire host_pins_pkg::modem_in_t MODEM_A_I,
    input  wire host_pins_pkg::modem_in_t MODEM_B_I,
    output logic [1:0]                  REQUEST_TO_SEND_N_O,
    input  wire logic [1:0]             TX_EMPTY_I,
    input  wire logic [1:0]             RX_AVAIL_I,
    input  wire logic [1:0]             ALL_SENT_I,
    input  wire logic [7:0]             RX_DATA_A_I,
    input  wire logic [7:0]             RX_DATA_B_I,
    output logic [7:0]                  TX_DATA_O,
    output logic [1:0]                  TX_LOAD_O,
    output logic [1:0]                  RX_TAKEN_O,
    output logic [1:0]                  TX_RUN_O,
    output logic [1:0]                  RX_RUN_O
);
    host_pins_pkg::chan_cfg_t cfg_r [2];
    logic [7:0] vsetup_r;
    logic [7:0] vbase_r;
    logic [1:0] proto_async_r;
    logic [5:0] stat_r;
    logic [5:0] mask_r;
    logic [5:0] stat_set;
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync3_r;
    logic [1:0] cts_n;
    logic [1:0] dcd_n;
    logic       daisy_n;
    logic       ack_n;
    logic       ack_fall;
    logic [1:0] tx_wr;
    logic [1:0] rx_rd;
    logic [1:0] tx_req_r;
    logic [1:0] rx_req_r;
    logic [1:0] tx_hold_r;
    logic [1:0] rx_hold_r;
    logic [1:0] tx_once_r;
    logic [1:0] tx_empty_d_r;
    logic [1:0] rx_avail_d_r;
    logic [1:0] rts_low_r;
    logic [5:0] enabled;
    logic       pending;
    logic       free_type;
    logic       gate;
    logic       dma_mux;
    logic [7:0] rd_nxt;

    // The first stage is read only by the second; edges use stages two and three.
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            sync1_r <= 6'h3F;
            sync2_r <= 6'h3F;
            sync3_r <= 6'h3F;
        end else begin
            sync1_r <= {VECTOR_ACK_N_I, DAISY_IN_N_I, MODEM_B_I.carrier_detect_n,
                        MODEM_A_I.carrier_detect_n, MODEM_B_I.clear_to_send_n,
                        MODEM_A_I.clear_to_send_n};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign cts_n    = sync2_r[1:0];
    assign dcd_n    = sync2_r[3:2];
    assign daisy_n  = sync2_r[4];
    assign ack_n    = sync2_r[5];
    assign ack_fall = sync3_r[5] && !ack_n;

    assign tx_wr = {WR_I && ADDR_I == `OFS_DATA_B, WR_I && ADDR_I == `OFS_DATA_A};
    assign rx_rd = {RD_I && ADDR_I == `OFS_DATA_B, RD_I && ADDR_I == `OFS_DATA_A};

    // Configuration registers.
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            vsetup_r      <= `REG_RST;
            vbase_r       <= `REG_RST;
            proto_async_r <= 2'h0;
            mask_r        <= `MASK_RST;
            for (int i = 0; i < 2; i++) begin
                cfg_r[i] <= '0;
            end
        end else if (WR_I) begin
            if (ADDR_I == `OFS_VSETUP) begin
                vsetup_r <= DATA_I;
            end else if (ADDR_I == `OFS_VBASE) begin
                vbase_r <= DATA_I;
            end else if (ADDR_I == `OFS_IDC_A) begin
                cfg_r[0].irq_dma_ctrl_reg <= DATA_I;
            end else if (ADDR_I == `OFS_IDC_B) begin
                cfg_r[1].irq_dma_ctrl_reg <= DATA_I;
            end else if (ADDR_I == `OFS_RXC_A) begin
                cfg_r[0].rx_ctrl_reg <= DATA_I;
            end else if (ADDR_I == `OFS_RXC_B) begin
                cfg_r[1].rx_ctrl_reg <= DATA_I;
            end else if (ADDR_I == `OFS_TXC_A) begin
                cfg_r[0].tx_ctrl_reg <= DATA_I;
            end else if (ADDR_I == `OFS_TXC_B) begin
                cfg_r[1].tx_ctrl_reg <= DATA_I;
            end else if (ADDR_I == `OFS_PROTO) begin
                proto_async_r <= DATA_I[1:0];
            end else if (ADDR_I == `OFS_IRQ_MASK) begin
                mask_r <= DATA_I[5:0];
            end
        end
    end

    // Transmit data goes straight to the core; a load pulse marks it.
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            TX_DATA_O  <= 8'h00;
            TX_LOAD_O  <= 2'h0;
            RX_TAKEN_O <= 2'h0;
        end else begin
            if (tx_wr != 2'h0) begin
                TX_DATA_O <= DATA_I;
            end
            TX_LOAD_O  <= tx_wr;
            RX_TAKEN_O <= rx_rd;
        end
    end

    // Sticky status: a new event in the clearing cycle keeps its bit.
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            stat_r <= `STAT_RST;
        end else if (WR_I && ADDR_I == `OFS_IRQ_STAT) begin
            stat_r <= (stat_r & ~DATA_I[5:0]) | stat_set;
        end else begin
            stat_r <= stat_r | stat_set;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic ext_edge;
            logic tx_gate;
            logic auto_en;

            assign ext_edge = (sync2_r[ch] ^ sync3_r[ch]) ||
                              (sync2_r[ch + 2] ^ sync3_r[ch + 2]);
            assign tx_gate  = cfg_r[ch].irq_dma_ctrl_reg[`IDC_TX_ALWAYS] ||
                              tx_once_r[ch];
            assign auto_en  = cfg_r[ch].rx_ctrl_reg[`RXC_AUTO];
            assign stat_set[`ST_EXT + ch] = ext_edge;
            assign stat_set[`ST_TX + ch]  = TX_EMPTY_I[ch] && !tx_empty_d_r[ch];
            assign stat_set[`ST_RX + ch]  = RX_AVAIL_I[ch] && !rx_avail_d_r[ch];
            assign enabled[`ST_EXT + ch]  = cfg_r[ch].irq_dma_ctrl_reg[`IDC_EXT_EN];
            assign enabled[`ST_TX + ch]   = 1'b1;
            assign enabled[`ST_RX + ch]   = 1'b1;

            // The hold bit stops a request from re-arming on the stale empty or
            // available level before the core has reacted to the access.
            always_ff @(posedge MCLK_I) begin
                if (!NRST_I) begin
                    tx_req_r[ch]     <= 1'b0;
                    tx_hold_r[ch]    <= 1'b0;
                    tx_once_r[ch]    <= 1'b0;
                    tx_empty_d_r[ch] <= 1'b0;
                end else begin
                    tx_empty_d_r[ch] <= TX_EMPTY_I[ch];
                    if (tx_wr[ch]) begin
                        tx_once_r[ch] <= 1'b1;
                    end
                    if (tx_wr[ch]) begin
                        tx_hold_r[ch] <= 1'b1;
                    end else if (!TX_EMPTY_I[ch]) begin
                        tx_hold_r[ch] <= 1'b0;
                    end
                    if (tx_wr[ch]) begin
                        tx_req_r[ch] <= 1'b0;
                    end else if (TX_EMPTY_I[ch] && tx_gate && !tx_hold_r[ch]) begin
                        tx_req_r[ch] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge MCLK_I) begin
                if (!NRST_I) begin
                    rx_req_r[ch]     <= 1'b0;
                    rx_hold_r[ch]    <= 1'b0;
                    rx_avail_d_r[ch] <= 1'b0;
                end else begin
                    rx_avail_d_r[ch] <= RX_AVAIL_I[ch];
                    if (rx_rd[ch]) begin
                        rx_hold_r[ch] <= 1'b1;
                    end else if (!RX_AVAIL_I[ch]) begin
                        rx_hold_r[ch] <= 1'b0;
                    end
                    if (rx_rd[ch]) begin
                        rx_req_r[ch] <= 1'b0;
                    end else if (RX_AVAIL_I[ch] && !rx_hold_r[ch]) begin
                        rx_req_r[ch] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge MCLK_I) begin
                if (!NRST_I) begin
                    TX_RUN_O[ch] <= 1'b0;
                    RX_RUN_O[ch] <= 1'b0;
                end else begin
                    TX_RUN_O[ch] <= cfg_r[ch].tx_ctrl_reg[`TXC_TX_EN] &&
                                    (!auto_en || !cts_n[ch]);
                    RX_RUN_O[ch] <= cfg_r[ch].rx_ctrl_reg[`RXC_RX_EN] &&
                                    (!auto_en || !dcd_n[ch]);
                end
            end

            // In async protocol with auto enable, request-to-send is held active after clearing so the last
            // character leaves the line before the modem drops carrier.
            always_ff @(posedge MCLK_I) begin
                if (!NRST_I) begin
                    REQUEST_TO_SEND_N_O[ch] <= 1'b1;
                end else if (!proto_async_r[ch] || !auto_en) begin
                    REQUEST_TO_SEND_N_O[ch] <= !cfg_r[ch].tx_ctrl_reg[`TXC_RTS];
                end else if (cfg_r[ch].tx_ctrl_reg[`TXC_RTS]) begin
                    REQUEST_TO_SEND_N_O[ch] <= 1'b0;
                end else if (ALL_SENT_I[ch]) begin
                    REQUEST_TO_SEND_N_O[ch] <= 1'b1;
                end
            end
            assign rts_low_r[ch] = !REQUEST_TO_SEND_N_O[ch];
        end
    endgenerate

    assign pending   = |(stat_r & mask_r & enabled);
    assign free_type = vsetup_r[`VS_VEC_MODE] &&
                       (vsetup_r[`VS_TYPE_HI:`VS_TYPE_LO] == `TYPE_FREE_A ||
                        vsetup_r[`VS_TYPE_HI:`VS_TYPE_LO] == `TYPE_FREE_B);
    assign gate      = free_type || !daisy_n;
    assign dma_mux   = vsetup_r[`VS_MUX_HI:`VS_MUX_LO] == `MUX_DMA;

    // Interrupt, chain and DMA pins.
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            IRQ_O                 <= 1'b0;
            IRQ_OE_O              <= 1'b0;
            DAISY_OUT_N_O         <= 1'b1;
            DMA_TX_REQ_A_O        <= 1'b0;
            DMA_RX_REQ_A_O        <= 1'b0;
            READY_A_OR_DMA_TX_B_O <= 1'b1;
            READY_B_OR_DMA_RX_B_O <= 1'b1;
        end else begin
            IRQ_O          <= 1'b0;
            IRQ_OE_O       <= pending && gate;
            DAISY_OUT_N_O  <= daisy_n || pending;
            DMA_TX_REQ_A_O <= tx_req_r[0];
            DMA_RX_REQ_A_O <= rx_req_r[0];
            if (dma_mux) begin
                READY_A_OR_DMA_TX_B_O <= tx_req_r[1];
                READY_B_OR_DMA_RX_B_O <= rx_req_r[1];
            end else begin
                READY_A_OR_DMA_TX_B_O <= !cfg_r[0].tx_ctrl_reg[`TXC_READY];
                READY_B_OR_DMA_RX_B_O <= !cfg_r[1].tx_ctrl_reg[`TXC_READY];
            end
        end
    end

    always_comb begin
        rd_nxt = 8'h00;
        if (ADDR_I == `OFS_DATA_A) begin
            rd_nxt = RX_DATA_A_I;
        end else if (ADDR_I == `OFS_DATA_B) begin
            rd_nxt = RX_DATA_B_I;
        end else if (ADDR_I == `OFS_VSETUP) begin
            rd_nxt = vsetup_r;
        end else if (ADDR_I == `OFS_VBASE) begin
            rd_nxt = vbase_r;
        end else if (ADDR_I == `OFS_IDC_A) begin
            rd_nxt = cfg_r[0].irq_dma_ctrl_reg;
        end else if (ADDR_I == `OFS_IDC_B) begin
            rd_nxt = cfg_r[1].irq_dma_ctrl_reg;
        end else if (ADDR_I == `OFS_RXC_A) begin
            rd_nxt = cfg_r[0].rx_ctrl_reg;
        end else if (ADDR_I == `OFS_RXC_B) begin
            rd_nxt = cfg_r[1].rx_ctrl_reg;
        end else if (ADDR_I == `OFS_TXC_A) begin
            rd_nxt = cfg_r[0].tx_ctrl_reg;
        end else if (ADDR_I == `OFS_TXC_B) begin
            rd_nxt = cfg_r[1].tx_ctrl_reg;
        end else if (ADDR_I == `OFS_PROTO) begin
            rd_nxt = {6'h00, proto_async_r};
        end else if (ADDR_I == `OFS_IRQ_STAT) begin
            rd_nxt = {2'h0, stat_r};
        end else if (ADDR_I == `OFS_IRQ_MASK) begin
            rd_nxt = {2'h0, mask_r};
        end else if (ADDR_I == `OFS_LINE) begin
            rd_nxt = {dcd_n, cts_n, RX_RUN_O, TX_RUN_O};
        end
    end

    // A host read wins over a vector cycle; the host never overlaps them.
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            DATA_O    <= 8'h00;
            DATA_OE_O <= 1'b0;
        end else if (RD_I) begin
            DATA_O    <= rd_nxt;
            DATA_OE_O <= 1'b1;
        end else if (ack_fall && vsetup_r[`VS_VEC_MODE] && !daisy_n) begin
            DATA_O    <= vbase_r;
            DATA_OE_O <= 1'b1;
        end else begin
            DATA_OE_O <= 1'b0;
        end
    end

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    a_bus_drive_read:  assert property (DATA_OE_O |-> $past(RD_I) ||
                          ($past(ack_fall) && $past(daisy_n) == 1'b0))
        else $error("data bus driven without a read or vector cycle");
    a_irq_pull_low:    assert property (IRQ_OE_O |-> $past(pending) && !IRQ_O)
        else $error("interrupt pulled without pending request");
    a_irq_free_type:   assert property (pending && free_type |=> IRQ_OE_O)
        else $error("unconditional type did not interrupt");
    a_vector_block:    assert property (ack_fall && daisy_n && !RD_I |=> !DATA_OE_O)
        else $error("vector driven with chain input high");
    a_chain_block:     assert property (daisy_n && !free_type |=> !IRQ_OE_O)
        else $error("interrupt raised while chain blocked");
    a_chain_out:       assert property (1'b1 |=> DAISY_OUT_N_O == ($past(daisy_n) || $past(pending)))
        else $error("chain output wrong");
    a_tx_first_write:  assert property (!tx_once_r[0] && !cfg_r[0].irq_dma_ctrl_reg[`IDC_TX_ALWAYS]
                          |=> ##1 !DMA_TX_REQ_A_O)
        else $error("transmit request before first write");
    a_tx_write_clear:  assert property (tx_wr[0] |=> ##1 !DMA_TX_REQ_A_O)
        else $error("transmit request not cleared by write");
    a_rx_read_clear:   assert property (rx_req_r[0] && !rx_rd[0] |=> rx_req_r[0])
        else $error("receive request dropped without read");
    a_ready_level:     assert property (!dma_mux |=> READY_A_OR_DMA_TX_B_O ==
                          !$past(cfg_r[0].tx_ctrl_reg[`TXC_READY]))
        else $error("ready pin level wrong");
    a_mux_rx_b:        assert property (dma_mux |=> READY_B_OR_DMA_RX_B_O == $past(rx_req_r[1]))
        else $error("shared pin not carrying receive request");
    a_ext_latch:       assert property (sync2_r[0] != sync3_r[0] |=> stat_r[`ST_EXT])
        else $error("clear-to-send change not latched");
    a_tx_auto_run:     assert property (cfg_r[0].rx_ctrl_reg[`RXC_AUTO] && cts_n[0] |=> !TX_RUN_O[0])
        else $error("transmitter ran with clear-to-send high");
    a_rx_auto_run:     assert property (cfg_r[0].rx_ctrl_reg[`RXC_AUTO] && dcd_n[0] |=> !RX_RUN_O[0])
        else $error("receiver ran with carrier high");
    a_rts_hold_sent:   assert property (rts_low_r[0] && proto_async_r[0] &&
                          cfg_r[0].rx_ctrl_reg[`RXC_AUTO] && !ALL_SENT_I[0] |=> rts_low_r[0])
        else $error("request-to-send released before all sent");
    a_rts_plain:       assert property (!proto_async_r[1] |=> REQUEST_TO_SEND_N_O[1] ==
                          !$past(cfg_r[1].tx_ctrl_reg[`TXC_RTS]))
        else $error("request-to-send not following its bit");
endmodule : host_irq_dma_modem_pins
`default_nettype wire

// ---- host_pins_regs.svh ----
/*
 * Register offsets, field positions, reset values and pin mux codes of the
 * host-side pin logic. Assumes it is included by bare name after the package.
 */
`ifndef HOST_PINS_REGS_SVH
`define HOST_PINS_REGS_SVH

`define OFS_DATA_A      4'h0
`define OFS_DATA_B      4'h1
`define OFS_VSETUP      4'h2
`define OFS_VBASE       4'h3
`define OFS_IDC_A       4'h4
`define OFS_IDC_B       4'h5
`define OFS_RXC_A       4'h6
`define OFS_RXC_B       4'h7
`define OFS_TXC_A       4'h8
`define OFS_TXC_B       4'h9
`define OFS_PROTO       4'hA
`define OFS_IRQ_STAT    4'hB
`define OFS_IRQ_MASK    4'hC
`define OFS_LINE        4'hD

`define VS_VEC_MODE     7
`define VS_TYPE_HI      5
`define VS_TYPE_LO      3
`define VS_MUX_HI       1
`define VS_MUX_LO       0
`define TYPE_FREE_A     3'h2
`define TYPE_FREE_B     3'h4
`define MUX_DMA         2'h2
`define IDC_EXT_EN      0
`define IDC_TX_ALWAYS   2
`define RXC_RX_EN       0
`define RXC_AUTO        5
`define TXC_RTS         1
`define TXC_TX_EN       3
`define TXC_READY       7
`define ST_EXT          0
`define ST_TX           2
`define ST_RX           4
`define REG_RST         8'h00
`define STAT_RST        6'h00
`define MASK_RST        6'h3F

`endif

// ---- host_pins_pkg.sv ----
/*
 * Types shared by the host-side pin logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package host_pins_pkg;
    typedef struct packed {
        logic [7:0] irq_dma_ctrl_reg;
        logic [7:0] rx_ctrl_reg;
        logic [7:0] tx_ctrl_reg;
    } chan_cfg_t;

    typedef struct packed {
        logic clear_to_send_n;
        logic carrier_detect_n;
    } modem_in_t;
endpackage : host_pins_pkg
`default_nettype wire

// ---- host_pins_partner.sv ----
/* Far-side model: the host data bus and the pulled-up interrupt line.
   Assumes the design's bus and interrupt outputs are wired to its ports by name. */
`timescale 1ns/1ns
`default_nettype none
module host_pins_partner (
    input  wire logic [7:0] data_i,
    input  wire logic       data_oe_i,
    input  wire logic       irq_i,
    input  wire logic       irq_oe_i,
    output logic      [7:0] bus_o,
    output logic            irq_n_o
);
    // A released bus shows the inverse of the last value, so a stale read cannot match.
    assign bus_o   = data_oe_i ? data_i : ~data_i;
    // The pull-up makes the released line read high.
    assign irq_n_o = irq_oe_i ? irq_i : 1'b1;
endmodule : host_pins_partner
`default_nettype wire

// ---- host_irq_dma_modem_pins_test.sv ----
/* Self-checking bench of the host-side pin logic, one task per scenario.
   Assumes the package, the design and the partner model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module host_irq_dma_modem_pins_test;
    logic                     mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ack_n = 1'b1;
    logic                     daisy_n = 1'b0, doe, irq, irq_oe, irq_n, dso, dtxa, drxa;
    logic                     pin_a, pin_b;
    logic [3:0]               addr = 4'h0;
    logic [7:0]               wdata = 8'h00, rxd_a = 8'h00, dout, bus, txd;
    logic [1:0]               tx_empty = 2'h0, rx_avail = 2'h0, all_sent = 2'h0;
    logic [1:0]               rts_n, txld, rxtk, txrun, rxrun;
    host_pins_pkg::modem_in_t modem_a = 2'h3;
    int                       num_errors = 0, total_checks = 0;

    always #50 mclk = ~mclk;

    host_irq_dma_modem_pins u_host_irq_dma_modem_pins (
        .MCLK_I(mclk), .NRST_I(nrst), .ADDR_I(addr), .DATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .DATA_O(dout), .DATA_OE_O(doe), .IRQ_O(irq), .IRQ_OE_O(irq_oe),
        .VECTOR_ACK_N_I(ack_n), .DAISY_IN_N_I(daisy_n), .DAISY_OUT_N_O(dso),
        .DMA_TX_REQ_A_O(dtxa), .DMA_RX_REQ_A_O(drxa), .READY_A_OR_DMA_TX_B_O(pin_a),
        .READY_B_OR_DMA_RX_B_O(pin_b), .MODEM_A_I(modem_a), .MODEM_B_I(2'h3),
        .REQUEST_TO_SEND_N_O(rts_n), .TX_EMPTY_I(tx_empty), .RX_AVAIL_I(rx_avail),
        .ALL_SENT_I(all_sent), .RX_DATA_A_I(rxd_a), .RX_DATA_B_I(8'h00), .TX_DATA_O(txd),
        .TX_LOAD_O(txld), .RX_TAKEN_O(rxtk), .TX_RUN_O(txrun), .RX_RUN_O(rxrun));
    host_pins_partner u_host_pins_partner (.data_i(dout), .data_oe_i(doe), .irq_i(irq),
        .irq_oe_i(irq_oe), .bus_o(bus), .irq_n_o(irq_n));

    task automatic close_out();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // A write ends one edge and a read two edges after its strobe drops, so strobes never collide.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
        chk(txld, {a == 4'h1, a == 4'h0});
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
        chk(dout, exp);
        chk(bus, exp);
        chk(rxtk, {a == 4'h1, a == 4'h0});
        tick(1);
        chk(doe, 1'b0);
    endtask : rd_reg
    task automatic vec(input logic want);
        logic       seen = 1'b0;
        logic [7:0] val = 8'h00;
        ack_n <= 1'b0;
        repeat (8) begin
            tick(1);
            seen = seen | (doe === 1'b1);
            if (doe === 1'b1) val = dout;
        end
        ack_n <= 1'b1;
        tick(4);
        chk(seen, want);
        if (want) chk(val, 8'hA5);
    endtask : vec

    task automatic s_reset();
        chk({dso, dtxa, pin_a, pin_b, rts_n, irq_oe}, 8'h5E);
        rd_reg(4'hC, 8'h3F);
        rd_reg(4'hE, 8'h00);
    endtask : s_reset
    task automatic s_dma();
        tx_empty <= 2'h3;
        tick(4);
        chk(dtxa, 1'b0);
        wr_reg(4'h0, 8'h5A);
        tx_empty <= 2'h2;
        tick(3);
        tx_empty <= 2'h3;
        tick(4);
        chk(txd, 8'h5A);
        chk(dtxa, 1'b1);
        wr_reg(4'h0, 8'h11);
        tick(2);
        chk(dtxa, 1'b0);
        wr_reg(4'h2, 8'h02);
        wr_reg(4'h5, 8'h04);
        tick(3);
        chk(pin_a, 1'b1);
        wr_reg(4'h1, 8'h22);
        tick(2);
        chk(pin_a, 1'b0);
        rxd_a <= 8'hC3;
        rx_avail <= 2'h3;
        tick(8);
        chk({drxa, pin_b}, 2'h3);
        rd_reg(4'h0, 8'hC3);
        tick(2);
        chk({drxa, pin_b}, 2'h1);
        rx_avail <= 2'h0;
    endtask : s_dma
    task automatic s_ready();
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h8, 8'h80);
        tick(2);
        chk({pin_a, pin_b}, 2'h1);
    endtask : s_ready
    task automatic s_irq();
        wr_reg(4'hB, 8'h3F);
        wr_reg(4'hC, 8'h03);
        wr_reg(4'h4, 8'h01);
        modem_a.clear_to_send_n <= 1'b0;
        tick(6);
        chk({irq_oe, irq_n, dso}, 3'h5);
        daisy_n <= 1'b1;
        tick(6);
        chk({irq_oe, irq_n, dso}, 3'h3);
        wr_reg(4'h3, 8'hA5);
        wr_reg(4'h2, 8'h90);
        tick(4);
        chk(irq_oe, 1'b1);
        wr_reg(4'h2, 8'hA0);
        tick(4);
        chk(irq_oe, 1'b1);
        vec(1'b0);
        daisy_n <= 1'b0;
        vec(1'b1);
        wr_reg(4'h2, 8'h80);
        daisy_n <= 1'b1;
        tick(6);
        chk(irq_oe, 1'b0);
        wr_reg(4'h2, 8'h00);
        daisy_n <= 1'b0;
        wr_reg(4'hB, 8'h01);
        tick(6);
        chk({dso, irq_n}, 2'h1);
    endtask : s_irq
    task automatic s_auto();
        wr_reg(4'h6, 8'h21);
        wr_reg(4'h8, 8'h08);
        modem_a <= 2'h1;
        tick(5);
        chk({rxrun, txrun}, 4'h1);
        modem_a <= 2'h2;
        tick(5);
        chk({rxrun, txrun}, 4'h4);
        wr_reg(4'hA, 8'h01);
        tick(2);
        chk(rts_n[0], 1'b1);
        wr_reg(4'h8, 8'h0A);
        tick(2);
        chk(rts_n[0], 1'b0);
        wr_reg(4'h8, 8'h08);
        tick(4);
        chk(rts_n[0], 1'b0);
        all_sent <= 2'h1;
        tick(3);
        chk(rts_n[0], 1'b1);
        wr_reg(4'h9, 8'h02);
        tick(2);
        chk(rts_n[1], 1'b0);
    endtask : s_auto

    initial begin
        tick(16);
        nrst <= 1'b1;
        tick(1);
        s_reset();
        s_dma();
        s_ready();
        s_irq();
        s_auto();
        close_out();
    end
    // A hang counts as a failure and still reaches the verdict.
    initial begin
        #1000000;
        num_errors++;
        close_out();
    end
endmodule : host_irq_dma_modem_pins_test
`default_nettype wire
